/* ign_pkg.sv */
// constants, field layouts and helpers for the ignition output sequencer
// assumes a 125 MHz core clock and a 32-bit classic wishbone register bus
package ign_pkg;

  // timing base
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS         = 1000;
  localparam int US_CYCLES     = US_NS / CLK_PERIOD_NS;
  localparam int MAX_CHARGE_US = 20000;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] DWELL_OFS  = 8'h04;
  localparam logic [7:0] TRIG_OFS   = 8'h08;
  localparam logic [7:0] ADV_OFS    = 8'h0C;
  localparam logic [7:0] STAT_OFS   = 8'h10;
  localparam logic [7:0] PERIOD_OFS = 8'h14;
  localparam logic [7:0] TABLE_OFS  = 8'h40;

  // timing mark table
  localparam int         TABLE_DEPTH = 30;
  localparam int         ANGLE_W     = 9;
  localparam logic [8:0] TABLE_END   = 9'h1FF;

  // control fields
  localparam int         CTRL_W    = 9;
  localparam int         PAT_LSB   = 0;
  localparam int         SENSE_BIT = 3;
  localparam int         TACH_BIT  = 4;
  localparam int         IGN4_BIT  = 5;
  localparam int         CYL_LSB   = 6;
  localparam int         EN_BIT    = 8;
  localparam logic [8:0] CTRL_RST  = 9'h000;

  // dwell in microseconds, advance in degrees before top dead centre
  localparam logic [15:0] DWELL_RST = 16'h0BB8;
  localparam logic [7:0]  ADV_RST   = 8'h00;

  // per-channel trigger fields, eight bits per channel
  localparam int          CH_W       = 8;
  localparam int          TRG_RELUC  = 0;
  localparam int          TRG_RISE   = 1;
  localparam int          TRG_FALL   = 2;
  localparam int          TRG_TIMING = 3;
  localparam int          TRG_RESET  = 4;
  localparam int          TRG_RTYPE  = 5;
  localparam int          TRG_MISS   = 7;
  localparam logic [23:0] TRIG_RST   = 24'h000000;

  // status fields
  localparam int STAT_WARN  = 0;
  localparam int STAT_SYNC  = 1;
  localparam int STAT_RWARN = 2;
  localparam int STAT_CYL   = 4;

  // period angle per cylinder count
  localparam logic [7:0] DEG_4CYL = 8'hB4;
  localparam logic [7:0] DEG_6CYL = 8'h78;
  localparam logic [7:0] DEG_8CYL = 8'h5A;

  typedef enum logic [2:0] {
    PAT_SIMULT, PAT_ALT, PAT_THREE, PAT_LEADTRAIL,
    PAT_FOUR, PAT_WASTED_2R, PAT_DIRECT_2R
  } pattern_e;

  typedef enum logic [1:0] {RST_PERIOD, RST_CRANK, RST_CAM} rst_type_e;

  // period angle from cylinder select
  function automatic logic [7:0] period_deg(input logic [1:0] sel);
    period_deg = (sel == 2'h1) ? DEG_6CYL :
                 (sel == 2'h2) ? DEG_8CYL : DEG_4CYL;
  endfunction : period_deg

  // number of spark events before a pattern repeats
  function automatic logic [2:0] pat_len(input logic [2:0] pat);
    unique case (pat)
      PAT_SIMULT: pat_len = 3'h1;
      PAT_THREE:  pat_len = 3'h3;
      PAT_FOUR:   pat_len = 3'h4;
      default:    pat_len = 3'h2;
    endcase
  endfunction : pat_len

  // coils charged for event k; bit 3 is the fourth coil drive
  function automatic logic [3:0] fire_mask(input logic [2:0] pat,
                                           input logic [1:0] k,
                                           input logic       tach,
                                           input logic       ign4);
    unique case (pat)
      PAT_SIMULT:    fire_mask = {ign4, ~tach, 2'h3};
      PAT_ALT:       fire_mask = k[0] ? 4'h2 : 4'h1;
      PAT_THREE:     fire_mask = 4'h1 << k;
      PAT_LEADTRAIL: fire_mask = 4'h3;
      PAT_FOUR:      fire_mask = 4'h1 << k;
      PAT_WASTED_2R: fire_mask = k[0] ? 4'h5 : 4'h3;
      PAT_DIRECT_2R: fire_mask = k[0] ? 4'hC : 4'h3;
      default:       fire_mask = 4'h0;
    endcase
  endfunction : fire_mask

endpackage : ign_pkg

/* trigger_channel.sv */
// one crank/cam trigger channel: pin synchroniser, edge select, missing tooth
// assumes us_tick_in pulses once per microsecond on the core clock
module trigger_channel (
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  input  wire logic       ce_in,
  input  wire logic       us_tick_in,
  input  wire logic       pin_in,
  input  wire logic [7:0] cfg_in,
  output logic            tooth_out,
  output logic            missing_out
);
  import ign_pkg::*;

  typedef struct packed {
    logic [2:0]  sync;
    logic        tooth;
    logic        missing;
    logic [23:0] gap;
    logic [23:0] last_gap;
  } chan_s;

  chan_s st_r;
  chan_s st_nxt;
  logic  rise;
  logic  fall;
  logic  hit;

  // edge qualify; a reluctor answers to falling edges alone
  always_comb begin
    st_nxt = st_r;
    rise   = st_r.sync[1] & ~st_r.sync[2];
    fall   = ~st_r.sync[1] & st_r.sync[2];
    hit    = (fall & cfg_in[TRG_FALL]) |
             (rise & cfg_in[TRG_RISE] & ~cfg_in[TRG_RELUC]);
    st_nxt.sync    = {st_r.sync[1:0], pin_in};
    st_nxt.tooth   = hit;
    st_nxt.missing = 1'b0;
    if (us_tick_in && st_r.gap != 24'hFFFFFF)
      st_nxt.gap = st_r.gap + 24'h000001;
    // gap over one and a half teeth marks the missing tooth
    if (hit) begin
      st_nxt.missing  = cfg_in[TRG_MISS] &&
        ({1'b0, st_r.gap} > {1'b0, st_r.last_gap} +
                            {2'h0, st_r.last_gap[23:1]});
      st_nxt.last_gap = st_r.gap;
      st_nxt.gap      = 24'h000000;
    end
  end

  // state register
  always_ff @(posedge core_clk_in) begin
    if (reset_in)
      st_r <= '0;
    else if (ce_in)
      st_r <= st_nxt;
  end

  assign tooth_out   = st_r.tooth;
  assign missing_out = st_r.missing;

  property p_reluc_rise;
    @(posedge core_clk_in) disable iff (reset_in)
    (ce_in && cfg_in[TRG_RELUC] && !cfg_in[TRG_FALL] && rise) |=> !tooth_out;
  endproperty
  a_reluc_rise: assert property (p_reluc_rise)
    else $error("reluctor channel answered a rising edge");

endmodule : trigger_channel

/* rate_divider.sv */
// serial divider giving microseconds per degree in 16.8 fixed point
// assumes start is a one-cycle pulse; a new start restarts the division
module rate_divider (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  input  wire logic        start_in,
  input  wire logic [23:0] num_in,
  input  wire logic [7:0]  den_in,
  output logic [23:0]      quot_out
);
  typedef struct packed {
    logic [5:0]  step;
    logic [31:0] rem;
    logic [31:0] dvd;
    logic [7:0]  den;
    logic [23:0] quot;
  } div_s;

  div_s        st_r;
  div_s        st_nxt;
  logic [32:0] trial;

  // one restoring step per cycle, result latched after 32 steps
  always_comb begin
    st_nxt = st_r;
    trial  = {st_r.rem, st_r.dvd[31]} - {25'h0, st_r.den};
    if (start_in) begin
      st_nxt.step = 6'h20;
      st_nxt.rem  = 32'h0;
      st_nxt.dvd  = {num_in, 8'h00};
      st_nxt.den  = den_in;
    end else if (st_r.step != 6'h0) begin
      st_nxt.step = st_r.step - 6'h1;
      st_nxt.dvd  = {st_r.dvd[30:0], ~trial[32]};
      st_nxt.rem  = trial[32] ? {st_r.rem[30:0], st_r.dvd[31]} : trial[31:0];
      if (st_r.step == 6'h1)
        st_nxt.quot = st_r.dvd[30:23] == 8'h0 ?
                      {st_r.dvd[22:0], ~trial[32]} :
                      24'hFFFFFF;
    end
  end

  // state register
  always_ff @(posedge core_clk_in) begin
    if (reset_in)
      st_r <= '0;
    else if (ce_in)
      st_r <= st_nxt;
  end

  assign quot_out = st_r.quot;

endmodule : rate_divider

/* ignition_output_sequencer.sv */
// ignition output sequencer: coil drive patterns, dwell and spark timing,
// three trigger channels and a classic wishbone register file
// assumes trigger pins are asynchronous and the bus runs on core_clk_in
//
// Summary of operation
// - fourth coil drive takes over auxiliary output one
// - simultaneous pattern fires all coils, tach optional
// - alternate pattern fires coils in turn, tach optional
// - three-cycle rotates first three coils
// - leading/trailing uses output three as address
// - four-cycle rotates four coils via auxiliary one
// - wasted-leading two-rotor: one leading, two trailing
// - direct-fire two-rotor: leading one/four, trailing two/three
// - first coil fires first after cam reset pulse
// - charge for dwell, release exactly at spark
// - falling sense: high charges, low sparks
// - rising sense inverts output polarity
// - warn when a coil stays charging too long
// - too long dwell starts at next tooth
// - alternating patterns allow dwell up to two periods
// - three channels, reluctor or digital
// - digital channel edges: rising, falling or both
// - reluctor channel responds to falling edges only
// - missing tooth detection, crank or cam reset
// - one spark per cylinder period angle
// - thirty table entries, minus one ends table
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
module ignition_output_sequencer (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic [2:0]  trig_pin_in,
  input  wire logic        aux1_req_in,
  output logic [2:0]       coil_out,
  output logic             aux1_out,
  output logic             warn_out
);
  import ign_pkg::*;

  typedef struct packed {
    logic                                   ack;
    logic [31:0]                            dat;
    logic [CTRL_W-1:0]                      ctrl;
    logic [15:0]                            dwell;
    logic [23:0]                            trig;
    logic [7:0]                             adv;
    logic [TABLE_DEPTH-1:0][ANGLE_W-1:0]    table_q;
    logic [6:0]                             us_div;
    logic                                   us_tick;
    logic [23:0]                            period_us;
    logic [23:0]                            per_cnt;
    logic [4:0]                             tidx;
    logic [1:0]                             cyl;
    logic                                   synced;
    logic                                   pend;
    logic                                   sparked;
    logic [23:0]                            spark_cnt;
    logic [3:0]                             charge;
    logic [3:0]                             mask;
    logic [15:0]                            chg_cnt;
    logic                                   warn;
    logic                                   tach;
    logic [2:0]                             coil;
    logic                                   aux1;
  } seq_s;

  seq_s        st_r;
  seq_s        st_nxt;
  logic [2:0]  tooth;
  logic [2:0]  missing;
  logic [23:0] us_per_deg;
  logic        div_start;

  // control decode
  logic [2:0]  pat;
  logic        rise_sense;
  logic        tach_en;
  logic        ign4_used;
  logic        alt_pat;
  logic [24:0] dwell_lim;
  logic [23:0] dwell_eff;

  // per-event temporaries
  logic        tooth_ev;
  logic        reset_ev;
  logic [1:0]  reset_type;
  logic [8:0]  angle;
  logic [8:0]  diff;
  logic [32:0] prod;
  logic [4:0]  idx_next;
  logic [2:0]  plen;
  logic        fire;
  logic [7:0]  rd_word;
  logic [31:0] rd_val;

  // merge byte lanes of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0]  sel);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = sel[i] ? wdat[8*i +: 8] : old[8*i +: 8];
  endfunction : merge

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chan
      trigger_channel u_chan (
        .core_clk_in (core_clk_in),
        .reset_in    (reset_in),
        .ce_in       (ce_in),
        .us_tick_in  (st_r.us_tick),
        .pin_in      (trig_pin_in[g]),
        .cfg_in      (st_r.trig[CH_W*g +: CH_W]),
        .tooth_out   (tooth[g]),
        .missing_out (missing[g])
      );
    end
  endgenerate

  rate_divider u_rate (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .ce_in       (ce_in),
    .start_in    (div_start),
    .num_in      (st_r.period_us),
    .den_in      (period_deg(st_r.ctrl[CYL_LSB +: 2])),
    .quot_out    (us_per_deg)
  );

  // decode of software settings
  always_comb begin
    pat        = st_r.ctrl[PAT_LSB +: 3];
    rise_sense = st_r.ctrl[SENSE_BIT];
    tach_en    = st_r.ctrl[TACH_BIT] &&
                 (pat == PAT_SIMULT || pat == PAT_ALT);
    ign4_used  = st_r.ctrl[IGN4_BIT] || pat == PAT_FOUR ||
                 pat == PAT_DIRECT_2R;
    plen       = pat_len(pat);
    alt_pat    = plen != 3'h1;
    dwell_lim  = alt_pat ? {st_r.period_us, 1'b0}
                         : {1'b0, st_r.period_us};
    dwell_eff  = ({9'h0, st_r.dwell} < dwell_lim) ? {8'h0, st_r.dwell}
                                                  : dwell_lim[23:0];
  end

  // sequencing, dwell, spark and register file
  always_comb begin
    st_nxt     = st_r;
    div_start  = 1'b0;
    tooth_ev   = 1'b0;
    reset_ev   = 1'b0;
    reset_type = RST_PERIOD;
    angle      = st_r.table_q[st_r.tidx];
    diff       = angle - {1'b0, st_r.adv};
    prod       = {24'h0, diff} * {9'h0, us_per_deg};
    idx_next   = st_r.tidx + 5'h1;
    fire       = 1'b0;
    rd_word    = wb_adr_in - TABLE_OFS;
    rd_val     = 32'h0;

    // microsecond time base
    st_nxt.us_tick = st_r.us_div == 7'(US_CYCLES - 1);
    st_nxt.us_div  = st_nxt.us_tick ? 7'h0 : st_r.us_div + 7'h1;
    if (st_r.us_tick && st_r.per_cnt != 24'hFFFFFF)
      st_nxt.per_cnt = st_r.per_cnt + 24'h1;

    // gather channel events
    for (int c = 0; c < 3; c++) begin
      if (st_r.trig[CH_W*c + TRG_TIMING] && tooth[c])
        tooth_ev = 1'b1;
      if (st_r.trig[CH_W*c + TRG_RESET] &&
          (st_r.trig[CH_W*c + TRG_MISS] ? missing[c] : tooth[c])) begin
        reset_ev   = 1'b1;
        reset_type = st_r.trig[CH_W*c + TRG_RTYPE +: 2];
      end
    end

    // timing teeth walk the mark table; a period ends at minus one
    if (tooth_ev) begin
      if (st_r.tidx == 5'h0) begin
        st_nxt.period_us = st_r.per_cnt;
        st_nxt.per_cnt   = 24'h0;
        st_nxt.sparked   = 1'b0;
        div_start        = 1'b1;
      end
      st_nxt.tidx = (idx_next == 5'(TABLE_DEPTH) ||
                     st_r.table_q[idx_next] == TABLE_END) ? 5'h0
                                                          : idx_next;
      // latest tooth at or before the spark angle sets the delay
      if (st_r.synced && st_r.ctrl[EN_BIT] && !st_r.sparked &&
          angle != TABLE_END && !angle[8] &&
          angle >= {1'b0, st_r.adv}) begin
        st_nxt.pend      = 1'b1;
        st_nxt.spark_cnt = prod[31:8];
        if (!st_r.pend)
          st_nxt.mask = fire_mask(pat, st_r.cyl, tach_en,
                                  st_r.ctrl[IGN4_BIT]);
      end
    end

    // reset pulse: table restarts, cylinder per reset type
    if (reset_ev) begin
      st_nxt.synced = 1'b1;
      st_nxt.tidx   = 5'h0;
      if (reset_type == RST_CAM)
        st_nxt.cyl = 2'h0;
      else if (reset_type == RST_CRANK)
        st_nxt.cyl = (st_r.cyl < 2'(plen >> 1)) ? 2'h0
                                                : 2'(plen >> 1);
    end

    // countdown to spark; the last microsecond releases the charge
    if (st_r.pend && st_r.us_tick) begin
      if (st_r.spark_cnt <= 24'h1) begin
        fire             = 1'b1;
        st_nxt.pend      = 1'b0;
        st_nxt.sparked   = 1'b1;
        st_nxt.tach      = ~st_r.tach;
        st_nxt.cyl       = (st_r.cyl == 2'(plen - 3'h1)) ? 2'h0
                                                         : st_r.cyl + 2'h1;
      end else begin
        st_nxt.spark_cnt = st_r.spark_cnt - 24'h1;
      end
    end
    // a cam pulse in the spark cycle still restarts at coil one
    if (reset_ev && reset_type == RST_CAM)
      st_nxt.cyl = 2'h0;

    // charge within dwell of the spark; a late tooth charges at once
    st_nxt.charge = (st_nxt.pend && st_nxt.spark_cnt <= dwell_eff)
                    ? st_nxt.mask : 4'h0;

    // stuck-on watch
    if (st_r.charge == 4'h0)
      st_nxt.chg_cnt = 16'h0;
    else if (st_r.us_tick && st_r.chg_cnt != 16'hFFFF)
      st_nxt.chg_cnt = st_r.chg_cnt + 16'h1;
    st_nxt.warn = st_r.chg_cnt >= 16'(MAX_CHARGE_US);

    // pin drive with sense applied
    st_nxt.coil[0] = st_r.charge[0] ^ rise_sense;
    st_nxt.coil[1] = st_r.charge[1] ^ rise_sense;
    if (pat == PAT_LEADTRAIL)
      st_nxt.coil[2] = st_r.cyl[0];
    else if (tach_en)
      st_nxt.coil[2] = st_r.tach;
    else
      st_nxt.coil[2] = st_r.charge[2] ^ rise_sense;
    st_nxt.aux1 = ign4_used ? st_r.charge[3] ^ rise_sense
                            : aux1_req_in;

    // wishbone classic slave, ack one cycle after the strobe
    st_nxt.ack = wb_cyc_in && wb_stb_in && !st_r.ack;
    unique case (wb_adr_in)
      CTRL_OFS:   rd_val = {23'h0, st_r.ctrl};
      DWELL_OFS:  rd_val = {16'h0, st_r.dwell};
      TRIG_OFS:   rd_val = {8'h0, st_r.trig};
      ADV_OFS:    rd_val = {24'h0, st_r.adv};
      STAT_OFS:   rd_val = {26'h0, st_r.cyl, 1'b0, rise_sense,
                            st_r.synced, st_r.warn};
      PERIOD_OFS: rd_val = {8'h0, st_r.period_us};
      default: begin
        if (wb_adr_in >= TABLE_OFS && wb_adr_in[1:0] == 2'h0 &&
            rd_word[7:2] < 6'(TABLE_DEPTH))
          rd_val = {{23{st_r.table_q[rd_word[6:2]][8]}},
                    st_r.table_q[rd_word[6:2]]};
      end
    endcase
    st_nxt.dat = rd_val;
    if (st_nxt.ack && wb_we_in) begin
      unique case (wb_adr_in)
        CTRL_OFS:   st_nxt.ctrl  = CTRL_W'(merge(32'(st_r.ctrl),
                                                 wb_dat_in, wb_sel_in));
        DWELL_OFS:  st_nxt.dwell = 16'(merge(32'(st_r.dwell),
                                             wb_dat_in, wb_sel_in));
        TRIG_OFS:   st_nxt.trig  = 24'(merge(32'(st_r.trig),
                                             wb_dat_in, wb_sel_in));
        ADV_OFS:    st_nxt.adv   = 8'(merge(32'(st_r.adv),
                                            wb_dat_in, wb_sel_in));
        default: begin
          if (wb_adr_in >= TABLE_OFS && wb_adr_in[1:0] == 2'h0 &&
              rd_word[7:2] < 6'(TABLE_DEPTH))
            st_nxt.table_q[rd_word[6:2]] =
              9'(merge(32'(st_r.table_q[rd_word[6:2]]),
                       wb_dat_in, wb_sel_in));
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_r         <= '0;
      st_r.ctrl    <= CTRL_RST;
      st_r.dwell   <= DWELL_RST;
      st_r.trig    <= TRIG_RST;
      st_r.adv     <= ADV_RST;
      st_r.table_q <= {TABLE_DEPTH{TABLE_END}};
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_out = st_r.dat;
  assign wb_ack_out = st_r.ack;
  assign coil_out   = st_r.coil;
  assign aux1_out   = st_r.aux1;
  assign warn_out   = st_r.warn;

  // spark event: charge ends on the microsecond tick at count one or less
  sequence s_spark;
    st_r.pend && st_r.us_tick && st_r.spark_cnt <= 24'h1 && ce_in;
  endsequence

  property p_ack_pulse;
    @(posedge core_clk_in) disable iff (reset_in)
    (wb_ack_out && ce_in) |=> !wb_ack_out;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack held longer than one cycle");

  property p_cam_reset;
    @(posedge core_clk_in) disable iff (reset_in)
    (ce_in && reset_ev && reset_type == RST_CAM && !fire) |=>
      st_r.cyl == 2'h0;
  endproperty
  a_cam_reset: assert property (p_cam_reset)
    else $error("cam reset did not return to first coil");

  property p_release;
    @(posedge core_clk_in) disable iff (reset_in)
    s_spark |=> st_r.charge == 4'h0 ##1 (!ce_in || st_r.coil[0] == rise_sense);
  endproperty
  a_release: assert property (p_release)
    else $error("coil not released at spark");

  property p_fall_sense;
    @(posedge core_clk_in) disable iff (reset_in)
    (ce_in && !rise_sense) |=> (!ce_in || coil_out[0] == $past(st_r.charge[0]));
  endproperty
  a_fall_sense: assert property (p_fall_sense)
    else $error("falling sense drive level wrong");

  property p_rise_sense;
    @(posedge core_clk_in) disable iff (reset_in)
    (ce_in && rise_sense) |=> (!ce_in || coil_out[1] != $past(st_r.charge[1]));
  endproperty
  a_rise_sense: assert property (p_rise_sense)
    else $error("rising sense drive not inverted");

  property p_aux_share;
    @(posedge core_clk_in) disable iff (reset_in)
    (ce_in && ign4_used) |=> (!ce_in ||
                              aux1_out == $past(st_r.charge[3] ^ rise_sense));
  endproperty
  a_aux_share: assert property (p_aux_share)
    else $error("auxiliary one not given to fourth coil");

  property p_three_one;
    @(posedge core_clk_in) disable iff (reset_in)
    (pat == PAT_THREE) |-> $onehot0(st_r.charge);
  endproperty
  a_three_one: assert property (p_three_one)
    else $error("three-cycle pattern charged two coils");

  property p_warn;
    @(posedge core_clk_in) disable iff (reset_in)
    (ce_in && st_r.chg_cnt >= 16'(MAX_CHARGE_US)) |=> (!ce_in || warn_out);
  endproperty
  a_warn: assert property (p_warn)
    else $error("stuck charge not flagged");

  property p_dwell_lim;
    @(posedge core_clk_in) disable iff (reset_in)
    st_r.period_us != 24'h0 |-> {1'b0, dwell_eff} <= dwell_lim;
  endproperty
  a_dwell_lim: assert property (p_dwell_lim)
    else $error("dwell exceeds allowed period span");

endmodule : ignition_output_sequencer

/* trig_wheel.sv */
// trigger wheel model: one tooth per period on pin 0, cam pulse on pin 1
// assumes cam_go_in is held across one window to give a single pulse
module trig_wheel #(parameter int PER = 6250) (
  input  wire logic       clk_in,
  input  wire logic       cam_go_in,
  output logic [2:0]      pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial pins_out = 3'h0;
  // tooth 2 us wide, cam pulse shortly before the next tooth
  always @(posedge clk_in) begin
    cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
    pins_out <= {1'b0, cam_go_in && cnt >= PER - 375 && cnt < PER - 125,
                 cnt < 250};
  end
endmodule : trig_wheel

/* test_ignition_output_sequencer.sv */
// bench for the ignition output sequencer over classic wishbone
// assumes trig_wheel drives the trigger pins
module test_ignition_output_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import ign_pkg::*;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, aux = 0, cam = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0, rd, q;
  logic [2:0]  pins, coil;
  logic        ack, aux1, warn;
  int          n_mismatch = 0, compares = 0;
  ignition_output_sequencer dut (.core_clk_in(clk), .reset_in(rst),
    .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wd), .wb_dat_out(rd),
    .wb_ack_out(ack), .trig_pin_in(pins), .aux1_req_in(aux),
    .coil_out(coil), .aux1_out(aux1), .warn_out(warn));
  trig_wheel wheel (.clk_in(clk), .cam_go_in(cam), .pins_out(pins));
  initial begin
    forever #4 clk = ~clk;
  end
  task chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task print_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // one classic cycle, entered just after a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
    q = rd;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask : bus
  // waits for a charge pulse, checks which coil and how long
  task fire(input logic [2:0] e, input string nm, input int lo, hi);
    int i, w;
    for (i = 0; i < 40000 && coil === 3'h0; i++) @(posedge clk);
    chk(nm, {29'h0, coil}, {29'h0, e});
    for (w = 0; w < 9000 && coil !== 3'h0; w++) @(posedge clk);
    chk("dwell_len", {31'h0, w > lo && w < hi}, 32'h1);
    if (i == 40000) print_verdict();
  endtask : fire
  task t_regs;
    bus(0, DWELL_OFS, 0);
    chk("dwell_rst", q, {16'h0, DWELL_RST});
    bus(0, 8'h30, 0);
    chk("unmapped", q, 32'h0);
    bus(1, CTRL_OFS, 32'h8);
    bus(0, STAT_OFS, 0);
    chk("sense", {31'h0, q[2]}, 32'h1);
    chk("rise_idle", {29'h0, coil}, 32'h7);
  endtask : t_regs
  task t_aux;
    aux <= 1;
    bus(1, CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk);
    chk("aux1_free", {31'h0, aux1}, 32'h1);
    bus(1, CTRL_OFS, 32'h20);
    repeat (3) @(posedge clk);
    chk("aux1_taken", {31'h0, aux1}, 32'h0);
    aux <= 0;
  endtask : t_aux
  // alternate pattern, one table mark at 90 deg, cam reset on channel 1
  task t_fire;
    int i;
    bus(1, DWELL_OFS, 32'h0F);
    bus(1, TABLE_OFS, 32'h5A);
    bus(1, TRIG_OFS, 32'h52_0A);
    bus(1, CTRL_OFS, 32'h101);
    repeat (15000) @(posedge clk);
    for (i = 0; i < 7000 && pins[0] !== 1'b1; i++) @(posedge clk);
    cam <= 1;
    repeat (6300) @(posedge clk);
    cam <= 0;
    fire(3'h1, "first_coil", 1800, 1950);
    fire(3'h2, "second_coil", 1800, 1950);
    chk("warn", {31'h0, warn}, 32'h0);
  endtask : t_fire
  // three-cycle pattern; usual dwell outlasts the spark delay at this speed
  task t_three;
    bus(1, DWELL_OFS, 32'hBB8);
    bus(1, CTRL_OFS, 32'h102);
    fire(3'h1, "three_c1", 2800, 3200);
    fire(3'h2, "three_c2", 2800, 3200);
    fire(3'h4, "three_c3", 2800, 3200);
  endtask : t_three
  initial begin
    repeat (4) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs();
    t_aux();
    t_fire();
    t_three();
    print_verdict();
  end
endmodule : test_ignition_output_sequencer
